// [logic/fsp_pkg.sv]
// Purpose: Shared constants for the flash page self-program sequencer and its CPU end
// Assumes: 25 MHz pclk, 16-bit instruction words, 32-word pages
// Notes:   Byte pointer: bit 0 unused, word field above it, page field above that
package fsp_pkg;

  localparam int unsigned CLK_NS       = 40;
  // Shortest erase or write time; the count rounds up to whole cycles
  localparam int unsigned PROG_TIME_NS = 3700000;
  localparam int unsigned PROG_CYCLES  = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;

  localparam int unsigned DATA_W     = 16;
  localparam int unsigned PTR_W      = 16;
  localparam int unsigned WORD_W     = 5;
  localparam int unsigned WORD_LSB   = 1;
  localparam int unsigned PAGE_W     = 7;
  localparam int unsigned PAGE_LSB   = 6;
  localparam int unsigned PAGE_WORDS = 32;

  // Store-program control register fields
  localparam int unsigned ENABLE_BIT  = 0;
  localparam int unsigned ERASE_BIT   = 1;
  localparam int unsigned WRITE_BIT   = 2;
  localparam int unsigned CLRBUF_BIT  = 4;
  localparam logic [7:0]  CSR_RESET   = 8'h00;
  localparam logic [7:0]  CSR_WMASK   = 8'h0F;
  localparam logic [7:0]  CMD_LOAD    = 8'h01;
  localparam logic [7:0]  CMD_ERASE   = 8'h03;
  localparam logic [7:0]  CMD_WRITE   = 8'h05;
  localparam logic [2:0]  ARM_WINDOW  = 3'h4;

  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  // CPU-end APB map
  localparam logic [7:0] CMD_OFF   = 8'h00;
  localparam logic [7:0] ZPTR_OFF  = 8'h04;
  localparam logic [7:0] RWORD_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF  = 8'h0C;
  localparam int unsigned DLY_LSB   = 8;
  localparam int unsigned DLY_W     = 3;
  localparam int unsigned ISSUE_BIT = 11;

  typedef enum logic [1:0] {
    FSP_IDLE  = 2'b00,
    FSP_ERASE = 2'b10,
    FSP_PROG  = 2'b01,
    FSP_WAIT  = 2'b11
  } fsp_state_t;

endpackage

// [logic/fsp_if.sv]
// Purpose: Link between the processor core end and the self-program sequencer
// Assumes: Both ends on pclk
// Notes:   csr_wr and store_exec are one-cycle pulses from the core end
`timescale 1ns/1ps
interface fsp_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic        csr_wr;
  logic [7:0]  csr_wdata;
  logic [7:0]  csr_rdata;
  logic        store_exec;
  logic [15:0] z_ptr;
  logic [15:0] r_word;
  logic        cpu_halt;

  modport dev (
    input  csr_wr, csr_wdata, store_exec, z_ptr, r_word,
    output csr_rdata, cpu_halt
  );
  modport cpu (
    output csr_wr, csr_wdata, store_exec, z_ptr, r_word,
    input  csr_rdata, cpu_halt
  );
endinterface

// [logic/fsp_dev.sv]
// Purpose: Flash page self-program sequencer: control register, page buffer, erase/write
// Assumes: ee_busy comes from the EEPROM controller on pclk
// Notes:   Flash array sits outside; it sees erase and per-word program strobes
`timescale 1ns/1ps

// Behaviour
// - Pattern 03 plus store instruction erases page
// - Erase uses page field only, ignores data
// - Core halted throughout page erase
// - Pattern 01 plus store instruction loads one word
// - Word field selects buffer location
// - Buffer cleared after write, clear bit, reset
// - Software loads each location once per clear
// - EEPROM write during loading discards buffer
// - Pattern 05 plus store instruction programs the page
// - Write takes page field; other bits zero
// - Core halted throughout page write
// - Software erases page before writing it
// - Loads allowed before or after erase
// - Buffer locations loadable in any order
// - Software uses same page for erase, write
// - Write bit clears on completion or timeout
// - Erase bit clears on completion or timeout
// - EEPROM write blocks all flash programming
module fsp_dev #(
  parameter int unsigned PROG_CYC = fsp_pkg::PROG_CYCLES
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  fsp_if.dev                               link,
  input  wire logic                        ee_busy,
  output logic                             fl_erase,
  output logic                             fl_prog,
  output logic [fsp_pkg::PAGE_W-1:0]       fl_page,
  output logic [fsp_pkg::WORD_W-1:0]       fl_word,
  output logic [fsp_pkg::DATA_W-1:0]       fl_data
);
  import fsp_pkg::*;

  function automatic logic cmd_is(input logic [7:0] csr, input logic [7:0] pat);
    cmd_is = ((csr & CSR_WMASK) == pat);
  endfunction

  fsp_state_t               state_ff;
  fsp_state_t               nxt_state;
  logic [7:0]               csr_ff;
  logic [7:0]               nxt_csr;
  logic [2:0]               win_ff;
  logic [2:0]               nxt_win;
  logic [31:0]              tmr_ff;
  logic [WORD_W-1:0]        idx_ff;
  logic [PAGE_W-1:0]        page_ff;
  logic                     was_wr_ff;
  logic [PAGE_WORDS-1:0]    vld_ff;
  logic [DATA_W-1:0]        buf_mem [PAGE_WORDS];
  logic                     fl_erase_ff;
  logic                     fl_prog_ff;
  logic [WORD_W-1:0]        fl_word_ff;
  logic [DATA_W-1:0]        fl_data_ff;

  wire                      idle      = (state_ff == FSP_IDLE);
  wire                      csr_take  = link.csr_wr && idle && !ee_busy;
  wire                      armed     = csr_ff[ENABLE_BIT] && (win_ff != 3'h0);
  // An EEPROM write in flight blocks arming and execution alike
  wire                      store_go  = link.store_exec && armed && idle && !ee_busy;
  wire                      do_erase  = store_go && cmd_is(csr_ff, CMD_ERASE);
  wire                      do_load   = store_go && cmd_is(csr_ff, CMD_LOAD);
  wire                      do_write  = store_go && cmd_is(csr_ff, CMD_WRITE);
  wire                      win_end   = armed && (win_ff == 3'h1) && !store_go;
  wire                      op_done   = (state_ff == FSP_WAIT) && (tmr_ff == 32'h0);
  wire [WORD_W-1:0]         z_word    = link.z_ptr[WORD_LSB +: WORD_W];
  wire [PAGE_W-1:0]         z_page    = link.z_ptr[PAGE_LSB +: PAGE_W];
  wire                      clr_write = op_done && was_wr_ff;
  wire                      clr_soft  = csr_take && link.csr_wdata[CLRBUF_BIT];
  wire                      clr_eep   = ee_busy && (|vld_ff);
  wire                      buf_clr   = clr_write || clr_soft || clr_eep;
  // A second load to a filled location is dropped, keeping the first word
  wire                      load_ok   = do_load && !vld_ff[z_word];
  wire                      last_word = (idx_ff == WORD_W'(PAGE_WORDS - 1));

  // Control register and its four-cycle arming window
  always_comb begin
    nxt_csr = csr_ff;
    nxt_win = win_ff;
    if (csr_take) begin
      nxt_csr = link.csr_wdata & CSR_WMASK;
      nxt_win = ARM_WINDOW;
    end else if (store_go) begin
      nxt_win = 3'h0;
      if (do_load || !(do_erase || do_write)) begin
        nxt_csr = CSR_RESET;
      end
    end else if (win_end) begin
      nxt_csr = CSR_RESET;
      nxt_win = 3'h0;
    end else if (op_done) begin
      nxt_csr = CSR_RESET;
    end else if (win_ff != 3'h0) begin
      nxt_win = win_ff - 3'h1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FSP_IDLE: begin
        if (do_erase) begin
          nxt_state = FSP_ERASE;
        end else if (do_write) begin
          nxt_state = FSP_PROG;
        end
      end
      FSP_ERASE: begin
        nxt_state = FSP_WAIT;
      end
      FSP_PROG: begin
        if (last_word) begin
          nxt_state = FSP_WAIT;
        end
      end
      FSP_WAIT: begin
        if (op_done) begin
          nxt_state = FSP_IDLE;
        end
      end
      default: begin
        nxt_state = FSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FSP_IDLE;
      csr_ff   <= CSR_RESET;
      win_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      csr_ff   <= nxt_csr;
      win_ff   <= nxt_win;
    end
  end

  // Page latched at command time; erase and write address the page independently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_ff   <= '0;
      was_wr_ff <= 1'b0;
      idx_ff    <= '0;
    end else begin
      if (do_erase || do_write) begin
        page_ff   <= z_page;
        was_wr_ff <= do_write;
        idx_ff    <= '0;
      end else if (state_ff == FSP_PROG) begin
        idx_ff <= idx_ff + WORD_W'(1);
      end
    end
  end

  // Duration of the erase or write; the core stays halted across it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_ff <= 32'h0;
    end else if (state_ff == FSP_ERASE || (state_ff == FSP_PROG && last_word)) begin
      tmr_ff <= 32'(PROG_CYC - 1);
    end else if (state_ff == FSP_WAIT && tmr_ff != 32'h0) begin
      tmr_ff <= tmr_ff - 32'h1;
    end
  end

  // Valid bits make clearing a one-cycle act; the words themselves need no reset.
  // Loads are taken only while idle, so an erase in between leaves them intact.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_ff <= '0;
    end else if (buf_clr) begin
      vld_ff <= '0;
    end else if (load_ok) begin
      vld_ff[z_word] <= 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (load_ok && !buf_clr) begin
      buf_mem[z_word] <= link.r_word;
    end
  end

  // Flash strobes; unloaded locations program as erased words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_erase_ff <= 1'b0;
      fl_prog_ff  <= 1'b0;
      fl_word_ff  <= '0;
      fl_data_ff  <= '0;
    end else begin
      fl_erase_ff <= (state_ff == FSP_ERASE);
      fl_prog_ff  <= (state_ff == FSP_PROG);
      fl_word_ff  <= idx_ff;
      fl_data_ff  <= vld_ff[idx_ff] ? buf_mem[idx_ff] : ERASED_WORD;
    end
  end

  assign fl_erase       = fl_erase_ff;
  assign fl_prog        = fl_prog_ff;
  assign fl_page        = page_ff;
  assign fl_word        = fl_word_ff;
  assign fl_data        = fl_data_ff;
  assign link.csr_rdata = csr_ff;
  assign link.cpu_halt  = !idle;

endmodule

// [logic/fsp_cpu.sv]
// Purpose: Processor-core end: turns APB orders into control writes and store pulses
// Assumes: One APB slave, zero wait except a command write while an order is pending or the core is halted
// Notes:   Store delay field lets software probe the arming window
`timescale 1ns/1ps
module fsp_cpu (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  fsp_if.cpu               link
);
  import fsp_pkg::*;

  logic [PTR_W-1:0]  z_ff;
  logic [DATA_W-1:0] r_ff;
  logic              csr_wr_ff;
  logic [7:0]        csr_wd_ff;
  logic              pend_ff;
  logic [DLY_W-1:0]  dly_ff;

  wire               hit_cmd  = (paddr == CMD_OFF);
  wire               hit_z    = (paddr == ZPTR_OFF);
  wire               hit_r    = (paddr == RWORD_OFF);
  wire               hit_st   = (paddr == STAT_OFF);
  wire               mapped   = hit_cmd || hit_z || hit_r || hit_st;
  // A new order waits while one is pending or the core is halted
  wire               busy     = pend_ff || csr_wr_ff || link.cpu_halt;
  wire               stall    = pwrite && hit_cmd && busy;
  wire               acc      = psel && penable && !stall;
  wire               wr_ok    = acc && pwrite && mapped;
  wire               exec_now = pend_ff && !csr_wr_ff && (dly_ff == '0) && !link.cpu_halt;
  // Issue the instruction delay+1 cycles after the control write lands
  wire [31:0]        stat_val = {16'h0, link.csr_rdata, 6'h0, pend_ff, link.cpu_halt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z_ff <= '0;
      r_ff <= '0;
    end else begin
      if (wr_ok && hit_z) begin
        z_ff <= pwdata[PTR_W-1:0];
      end
      if (wr_ok && hit_r) begin
        r_ff <= pwdata[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_wr_ff <= 1'b0;
      csr_wd_ff <= 8'h00;
      pend_ff   <= 1'b0;
      dly_ff    <= '0;
    end else begin
      csr_wr_ff <= wr_ok && hit_cmd;
      if (wr_ok && hit_cmd) begin
        csr_wd_ff <= pwdata[7:0];
        pend_ff   <= pwdata[ISSUE_BIT];
        dly_ff    <= pwdata[DLY_LSB +: DLY_W];
      end else if (exec_now) begin
        pend_ff <= 1'b0;
      end else if (pend_ff && !csr_wr_ff && dly_ff != '0) begin
        dly_ff <= dly_ff - DLY_W'(1);
      end
    end
  end

  assign prdata         = hit_z  ? {16'h0, z_ff} :
                          hit_r  ? {16'h0, r_ff} :
                          hit_st ? stat_val : 32'h0;
  assign pready         = !(psel && penable && stall);
  assign pslverr        = psel && penable && !mapped;
  assign link.csr_wr    = csr_wr_ff;
  assign link.csr_wdata = csr_wd_ff;
  assign link.store_exec = exec_now;
  assign link.z_ptr     = z_ff;
  assign link.r_word    = r_ff;

endmodule

// [dv/fsp_monitor.sv]
// Purpose: Checker on the link between core end and sequencer
// Assumes: One clock; PROG_CYC matches the sequencer instance
// Notes:   EEPROM busy is not visible here, so the bench keeps it low around armed commands
`timescale 1ns/1ps
module fsp_monitor #(
  parameter int unsigned PROG_CYC = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        csr_wr,
  input wire logic [7:0]  csr_wdata,
  input wire logic [7:0]  csr_rdata,
  input wire logic        store_exec,
  input wire logic [15:0] z_ptr,
  input wire logic [15:0] r_word,
  input wire logic        cpu_halt
);
  // Longest halt is a page write: 32 program cycles plus the wait
  localparam int HMAX = PROG_CYC + 48;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_erase_halts: assert property (store_exec && csr_rdata[3:0] == 4'h3 |=> cpu_halt)
    else $error("erase did not halt core");
  a_write_halts: assert property (store_exec && csr_rdata[3:0] == 4'h5 |=> cpu_halt)
    else $error("page write did not halt core");
  a_load_once: assert property (store_exec && csr_rdata[3:0] == 4'h1 |=>
    csr_rdata == 8'h00 && !cpu_halt) else $error("load left control set");
  a_window_expiry: assert property ($rose(csr_rdata[0]) ##0 (!store_exec)[*4] |=>
    csr_rdata == 8'h00) else $error("arming window not closed");
  a_unarmed_exec: assert property (store_exec && !csr_rdata[0] |=> !cpu_halt)
    else $error("unarmed store-program acted");
  a_halt_end: assert property ($fell(cpu_halt) |-> csr_rdata == 8'h00)
    else $error("command bits left after operation");
  a_halt_min: assert property ($rose(cpu_halt) |-> cpu_halt[*8])
    else $error("halt too short");
  a_halt_bound: assert property ($rose(cpu_halt) |-> ##[1:HMAX] !cpu_halt)
    else $error("halt never ended");
  a_core_stopped: assert property (cpu_halt |-> !csr_wr && !store_exec)
    else $error("core active while halted");
  a_cmd_held: assert property (cpu_halt && $past(cpu_halt) |-> $stable(csr_rdata))
    else $error("control changed mid operation");

  c_erase: cover property (store_exec && csr_rdata[3:0] == 4'h3);
  c_write: cover property (store_exec && csr_rdata[3:0] == 4'h5);
  c_load: cover property (store_exec && csr_rdata[3:0] == 4'h1);
  c_expiry: cover property ($rose(csr_rdata[0]) ##0 (!store_exec)[*4]);
endmodule

// [dv/tb_top.sv]
// Purpose: Bench for core end and sequencer joined by their link
// Assumes: Short program time; APB master per the bus rules
// Notes:   Flash strobes are recorded into a page image and compared whole
`timescale 1ns/1ps
module tb_top;
  import fsp_pkg::*;
  localparam int unsigned PC = 20;
  typedef struct {logic [4:0] idx; logic [15:0] dat; logic [15:0] exp;} fsp_row_t;
  logic                        pclk, presetn, psel, penable, pwrite, ee_busy;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata, rd;
  logic                        pready, pslverr, er, fl_erase, fl_prog;
  logic [PAGE_W-1:0]           fl_page, epg, ppg;
  logic [WORD_W-1:0]           fl_word;
  logic [DATA_W-1:0]           fl_data;
  logic [DATA_W-1:0]           got [PAGE_WORDS], expp [PAGE_WORDS];
  int                          err_count, tests_run, n_ers, n_prg, cyc;
  // Last row reloads a used slot: the first word must survive
  fsp_row_t rows [4] = '{'{5'h1F, 16'hA55A, 16'hA55A}, '{5'h00, 16'h1234, 16'h1234},
                         '{5'h07, 16'h0F0F, 16'h0F0F}, '{5'h1F, 16'hDEAD, 16'hA55A}};

  fsp_if u_fsp_if (.pclk(pclk), .presetn(presetn));
  fsp_cpu u_fsp_cpu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(u_fsp_if));
  fsp_dev #(.PROG_CYC(PC)) u_fsp_dev (.pclk(pclk), .presetn(presetn), .link(u_fsp_if),
    .ee_busy(ee_busy), .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_page(fl_page),
    .fl_word(fl_word), .fl_data(fl_data));
  fsp_monitor #(.PROG_CYC(PC)) u_fsp_monitor (.pclk(pclk), .presetn(presetn),
    .csr_wr(u_fsp_if.csr_wr), .csr_wdata(u_fsp_if.csr_wdata), .csr_rdata(u_fsp_if.csr_rdata),
    .store_exec(u_fsp_if.store_exec), .z_ptr(u_fsp_if.z_ptr), .r_word(u_fsp_if.r_word),
    .cpu_halt(u_fsp_if.cpu_halt));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (fl_erase === 1'b1) begin
      n_ers++;
      epg = fl_page;
    end
    if (fl_prog === 1'b1) begin
      n_prg++;
      ppg = fl_page;
      got[fl_word] = fl_data;
    end
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] v, input logic [2:0] d);
    apb(1'b1, CMD_OFF, {20'h0, 1'b1, d, v});
  endtask

  task automatic wait_idle();
    do apb(1'b0, STAT_OFF, 32'h0); while (rd[1:0] !== 2'b00);
  endtask

  task automatic load(input logic [4:0] i, input logic [15:0] d, input logic [6:0] pg);
    apb(1'b1, ZPTR_OFF, {19'h0, pg, i, 1'b0});
    apb(1'b1, RWORD_OFF, {16'h0, d});
    cmd(CMD_LOAD, 3'h0);
  endtask

  task automatic op(input logic [7:0] c, input logic [15:0] z, input logic [2:0] d);
    n_ers = 0;
    n_prg = 0;
    apb(1'b1, ZPTR_OFF, {16'h0, z});
    cmd(c, d);
    wait_idle();
  endtask

  task automatic init_exp();
    foreach (expp[i]) expp[i] = ERASED_WORD;
  endtask

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_page(input logic [6:0] pg);
    chk_val(32'(n_prg), 32'd32);
    chk_val({25'h0, ppg}, {25'h0, pg});
    foreach (expp[i]) chk_val({16'h0, got[i]}, {16'h0, expp[i]});
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, ee_busy, paddr, pwdata} = '0;
    {err_count, tests_run, n_ers, n_prg, cyc} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STAT_OFF, 32'h0);
    chk_val(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk_val({rd[30:0], er}, 32'h1);
    init_exp();
    foreach (rows[r]) begin
      load(rows[r].idx, rows[r].dat, 7'h05);
      expp[rows[r].idx] = rows[r].exp;
    end
    apb(1'b0, ZPTR_OFF, 32'h0);
    chk_val(rd, 32'h0000017E);
    apb(1'b0, RWORD_OFF, 32'h0);
    chk_val(rd, 32'h0000DEAD);
    // Junk in the word and top bits must not move the erased page
    op(CMD_ERASE, 16'hF6AB, 3'h0);
    chk_val(32'(n_ers), 32'd1);
    chk_val({25'h0, epg}, 32'h5A);
    op(CMD_WRITE, 16'h1680, 3'h0);
    chk_page(7'h5A);
    init_exp();
    load(5'h02, 16'h5555, 7'h04);
    apb(1'b1, CMD_OFF, 32'h10);
    load(5'h02, 16'hBEEF, 7'h04);
    expp[2] = 16'hBEEF;
    op(CMD_ERASE, 16'h0100, 3'h0);
    op(CMD_WRITE, 16'h0100, 3'h0);
    chk_page(7'h04);
    init_exp();
    op(CMD_ERASE, 16'h0100, 3'h0);
    load(5'h05, 16'h7777, 7'h04);
    ee_busy <= 1'b1;
    repeat (3) @(posedge pclk);
    ee_busy <= 1'b0;
    op(CMD_WRITE, 16'h0100, 3'h0);
    chk_page(7'h04);
    ee_busy <= 1'b1;
    op(CMD_ERASE, 16'h0100, 3'h0);
    chk_val(32'(n_ers), 32'd0);
    ee_busy <= 1'b0;
    for (int d = 3; d < 5; d++) begin
      op(CMD_ERASE, 16'h0100, 3'(d));
      chk_val(32'(n_ers), 32'(d == 3));
    end
    op(CMD_WRITE, 16'h0100, 3'h4);
    chk_val(32'(n_prg), 32'd0);
    load(5'h01, 16'h3C3C, 7'h06);
    // Let the load land so that only the reset can empty the buffer
    wait_idle();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    init_exp();
    op(CMD_ERASE, 16'h0180, 3'h0);
    op(CMD_WRITE, 16'h0180, 3'h0);
    chk_page(7'h06);
    tally_and_finish();
  end
endmodule
